// *** vcs_top.sv ***
// valve mode, protection, local button and cutoff supervisor with AHB-Lite registers
// assumes one hclk domain; button and aux short come from pins
`default_nettype none
module vcs_top
    import vcs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic signed [7:0] setpoint_pct,
    input wire logic signed [7:0] travel_pct,
    input wire logic travel_valid,
    input wire logic signed [7:0] pressure_pct,
    input wire logic cal_button,
    input wire logic aux_short,
    input wire logic autocal_done,
    input wire logic alert_event,
    output logic signed [7:0] travel_target,
    output logic signed [7:0] reported_travel,
    output logic pressure_ctl,
    output logic autocal_run,
    output logic stroke_test_start,
    output logic [1:0] control_mode,
    output logic [5:0] polling_addr,
    output logic write_protected,
    output logic in_service
);
    function automatic logic hold_ok(input logic [13:0] ms);
        hold_ok = (ms >= START_MIN_MS) && (ms <= START_MAX_MS);
    endfunction
    function automatic logic signed [7:0] sat(input logic signed [8:0] v);
        if (v > 9'(P_OFF_HI))
            sat = P_OFF_HI;
        else if (v < 9'(P_OFF_LO))
            sat = P_OFF_LO;
        else
            sat = v[7:0];
    endfunction
    // bus: one wait state on reads so read data always comes from a flop
    logic wr_ph_reg, rd_ph_reg, rd_done_reg;
    logic [11:0] addr_reg;
    logic [31:0] rdata_reg;
    wire take = hsel && htrans[1] && hready;
    assign hreadyout = !(rd_ph_reg && !rd_done_reg);
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    vcs_ctrl_t ctrl_reg;
    vcs_cut_t cut_reg;
    vcs_sel_t sel_pend_reg, sel_reg;
    vcs_cmode_t mode_reg, mode_prev_reg;
    logic [15:0] rate_reg;
    logic [23:0] dev_reg;
    logic [5:0] paddr_reg, paddr_pend_reg;
    logic wp_reg, unlock_reg, oos_d_reg;
    logic [31:0] id_mem [ID_WORDS];
    logic [16:0] sec_reg;
    logic [14:0] day_reg;
    logic [31:0] stamp_reg;
    wire wr = wr_ph_reg;
    wire cfg_ok = wr && !wp_reg;
    wire w_ctrl = wr && addr_reg == A_CTRL;
    wire in_id = addr_reg >= A_ID && addr_reg < A_ID_END;
    wire [4:0] id_idx = 5'(addr_reg[11:2] - A_ID[11:2]);
    wire [5:0] paddr_max = ctrl_reg.hart7 ? PADDR_MAX7 : PADDR_MAX5;
    wire restart = w_ctrl && hwdata[B_RESTART];
    wire back_in = oos_d_reg && !ctrl_reg.oos;
    wire apply = back_in || restart;
    // pin sampling: a change counts once stages two and three agree
    logic [2:0] btn_sh, aux_sh;
    logic btn_lvl, aux_lvl;
    logic [13:0] btn_ms, aux_ms;
    logic [16:0] ms_cnt;
    logic [9:0] s_cnt;
    wire tick = ms_cnt == 17'(MS_CYCLES - 1);
    wire btn_rel = btn_lvl && btn_sh[2:1] == 2'b00;
    wire aux_rel = aux_lvl && aux_sh[2:1] == 2'b00;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            btn_sh <= 3'h0;
            aux_sh <= 3'h0;
            btn_lvl <= 1'b0;
            aux_lvl <= 1'b0;
            btn_ms <= 14'h0;
            aux_ms <= 14'h0;
            ms_cnt <= 17'h0;
        end else begin
            btn_sh <= {btn_sh[1:0], cal_button};
            aux_sh <= {aux_sh[1:0], aux_short};
            if (btn_sh[2] == btn_sh[1])
                btn_lvl <= btn_sh[2];
            if (aux_sh[2] == aux_sh[1])
                aux_lvl <= aux_sh[2];
            ms_cnt <= tick ? 17'h0 : ms_cnt + 17'h1;
            // hold timers saturate so a stuck contact never wraps into range
            if (!btn_lvl)
                btn_ms <= 14'h0;
            else if (tick && btn_ms != 14'h3fff)
                btn_ms <= btn_ms + 14'h1;
            if (!aux_lvl)
                aux_ms <= 14'h0;
            else if (tick && aux_ms != 14'h3fff)
                aux_ms <= aux_ms + 14'h1;
        end
    end
    // autocalibration and stroke test from the local contacts
    wire cal_start = btn_rel && hold_ok(btn_ms) && ctrl_reg.cal_en && !wp_reg && !autocal_run;
    wire cal_abort = btn_rel && autocal_run && btn_ms >= ABORT_MS;
    wire unlock_press = btn_rel && unlock_reg && btn_ms >= ABORT_MS;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            autocal_run <= 1'b0;
            stroke_test_start <= 1'b0;
        end else begin
            stroke_test_start <= aux_rel && hold_ok(aux_ms) && ctrl_reg.aux_en;
            if (cal_start)
                autocal_run <= 1'b1;
            else if (cal_abort || autocal_done)
                autocal_run <= 1'b0;
        end
    end
    // control mode: test while autocalibrating, restart setting on restart
    wire mode_wr = w_ctrl && hwdata[B_MODE_WR] && !wp_reg && hwdata[B_MODE + 1] == 1'b0 && !autocal_run;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= CM_ANALOG;
            mode_prev_reg <= CM_ANALOG;
        end else if (cal_start) begin
            mode_prev_reg <= mode_reg;
            mode_reg <= CM_TEST;
        end else if (autocal_done && autocal_run) begin
            mode_reg <= mode_prev_reg; // aborted runs stay in
        end else if (restart && !autocal_run) begin
            case (ctrl_reg.restart)
                RS_ANALOG: mode_reg <= CM_ANALOG;
                RS_DIGITAL: mode_reg <= CM_DIGITAL;
                default: mode_reg <= mode_reg;
            endcase
        end else if (mode_wr) begin
            mode_reg <= hwdata[B_MODE] ? CM_DIGITAL : CM_ANALOG;
        end
    end
    assign control_mode = mode_reg;
    // configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RST;
            cut_reg <= CUT_RST;
            rate_reg <= RATE_RST;
            dev_reg <= DEV_RST;
            sel_pend_reg <= SEL_TRAVEL;
            sel_reg <= SEL_TRAVEL;
            paddr_reg <= 6'h0;
            paddr_pend_reg <= 6'h0;
            wp_reg <= 1'b0;
            unlock_reg <= 1'b0;
            oos_d_reg <= 1'b0;
        end else begin
            oos_d_reg <= ctrl_reg.oos;
            if (w_ctrl && hwdata[B_WP_SET])
                wp_reg <= 1'b1;
            else if (unlock_press)
                wp_reg <= 1'b0;
            if (w_ctrl && hwdata[B_UNLOCK] && wp_reg)
                unlock_reg <= 1'b1;
            else if (unlock_press || !wp_reg)
                unlock_reg <= 1'b0;
            if (cfg_ok && addr_reg == A_CTRL) begin
                ctrl_reg <= {hwdata[9:7], sel_reg, hwdata[4:0]};
                if (ctrl_reg.oos)
                    sel_pend_reg <= vcs_sel_t'(hwdata[6:5]);
            end
            if (cfg_ok && addr_reg == A_PADDR && ctrl_reg.oos && hwdata[31:6] == 26'h0 && hwdata[5:0] <= paddr_max)
                paddr_pend_reg <= hwdata[5:0];
            if (cfg_ok && addr_reg == A_CUT)
                cut_reg <= hwdata[17:0];
            if (cfg_ok && addr_reg == A_RATE)
                rate_reg <= hwdata[15:0];
            if (cfg_ok && addr_reg == A_DEV)
                dev_reg <= hwdata[23:0];
            if (apply) begin
                sel_reg <= sel_pend_reg;
                paddr_reg <= paddr_pend_reg;
            end
        end
    end
    assign write_protected = wp_reg;
    assign in_service = !ctrl_reg.oos;
    assign polling_addr = paddr_reg;
    always_ff @(posedge hclk) begin
        if (cfg_ok && in_id)
            id_mem[id_idx] <= hwdata;
    end
    // instrument clock and alert stamps
    wire [31:0] clk_word = {day_reg, sec_reg};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_cnt <= 10'h0;
            sec_reg <= 17'h0;
            day_reg <= 15'h0;
            stamp_reg <= 32'h0;
        end else begin
            if (alert_event)
                stamp_reg <= clk_word;
            if (cfg_ok && addr_reg == A_CLK) begin
                sec_reg <= hwdata[16:0];
                day_reg <= hwdata[31:17];
                s_cnt <= 10'h0;
            end else if (tick) begin
                s_cnt <= (s_cnt == MS_PER_S - 10'h1) ? 10'h0 : s_cnt + 10'h1;
                if (s_cnt == MS_PER_S - 10'h1) begin
                    if (sec_reg == SEC_PER_DAY - 17'h1) begin
                        sec_reg <= 17'h0;
                        day_reg <= day_reg + 15'h1;
                    end else begin
                        sec_reg <= sec_reg + 17'h1;
                    end
                end
            end
        end
    end
    // travel target: ranging, limits, cutoffs and soft ramps
    wire signed [8:0] sp9 = {setpoint_pct[7], setpoint_pct};
    wire signed [7:0] ranged = sat(ctrl_reg.zpc_open ? P_FULL - sp9 : sp9);
    wire hi_on = cut_reg.hi_pt != P_OFF_HI;
    wire lo_on = cut_reg.lo_pt != P_OFF_LO;
    wire hi_cut = hi_on && cut_reg.hi_cut && travel_pct > cut_reg.hi_pt;
    wire lo_cut = lo_on && cut_reg.lo_cut && travel_pct < cut_reg.lo_pt;
    wire signed [7:0] lim_hi = (hi_on && !cut_reg.hi_cut && ranged > cut_reg.hi_pt) ? cut_reg.hi_pt : ranged;
    wire signed [7:0] limited = (lo_on && !cut_reg.lo_cut && lim_hi < cut_reg.lo_pt) ? cut_reg.lo_pt : lim_hi;
    wire signed [7:0] goal = hi_cut ? P_CUT_HI : lo_cut ? P_CUT_LO : limited;
    wire [7:0] rate = hi_cut ? rate_reg[7:0] : rate_reg[15:8];
    wire ramping = (hi_cut || lo_cut) && rate != 8'h0;
    logic [10:0] acc_reg;
    wire step = acc_reg >= 11'(MS_PER_S);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            travel_target <= 8'sh00;
            acc_reg <= 11'h0;
        end else if (!ramping) begin
            travel_target <= goal;
            acc_reg <= 11'h0;
        end else begin
            // rate is in %/s, accumulated per ms, one percent per step
            if (step)
                acc_reg <= acc_reg - 11'(MS_PER_S);
            else if (tick)
                acc_reg <= acc_reg + 11'(rate);
            if (step && travel_target < goal)
                travel_target <= travel_target + 8'sh01;
            else if (step && travel_target > goal)
                travel_target <= travel_target - 8'sh01;
        end
    end
    // pressure fallback
    logic fb_reg;
    logic [15:0] dev_ms;
    wire signed [8:0] dev = {travel_target[7], travel_target} - {travel_pct[7], travel_pct};
    wire dev_hi = dev > $signed({1'b0, dev_reg[7:0]});
    wire sens_fail = !travel_valid && (sel_reg == SEL_FB_SENS || sel_reg == SEL_FB_DEV);
    wire dev_trip = sel_reg == SEL_FB_DEV && dev_hi && dev_ms >= dev_reg[23:8];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_reg <= 1'b0;
            dev_ms <= 16'h0;
        end else begin
            if (!dev_hi || sel_reg != SEL_FB_DEV)
                dev_ms <= 16'h0;
            else if (tick && dev_ms != 16'hffff)
                dev_ms <= dev_ms + 16'h1;
            if (sens_fail || dev_trip)
                fb_reg <= 1'b1;
            else if (ctrl_reg.rec_auto && travel_valid && !dev_hi)
                fb_reg <= 1'b0; // auto recovery needs rec_auto, valid travel and no deviation
            else if (sel_reg == SEL_TRAVEL || sel_reg == SEL_PRESS)
                fb_reg <= 1'b0;
        end
    end
    assign pressure_ctl = sel_reg == SEL_PRESS || fb_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            reported_travel <= 8'sh00;
        else
            reported_travel <= (pressure_ctl || !travel_valid) ? pressure_pct : travel_pct;
    end
    // read mux and bus phases
    wire [31:0] stat_word = {20'h0, sel_pend_reg, sel_reg, mode_reg, travel_valid, fb_reg, autocal_run,
        unlock_reg, wp_reg, ctrl_reg.oos};
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0;
        if (in_id)
            rd_word = id_mem[id_idx];
        case (addr_reg)
            A_CTRL: rd_word = {22'h0, ctrl_reg};
            A_PADDR: rd_word = {26'h0, paddr_pend_reg};
            A_CUT: rd_word = {14'h0, cut_reg};
            A_RATE: rd_word = {16'h0, rate_reg};
            A_DEV: rd_word = {8'h0, dev_reg};
            A_STAT: rd_word = stat_word;
            A_CLK: rd_word = clk_word;
            A_STAMP: rd_word = stamp_reg;
            default: rd_word = rd_word;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_reg <= 1'b0;
            rd_ph_reg <= 1'b0;
            rd_done_reg <= 1'b0;
            addr_reg <= 12'h0;
            rdata_reg <= 32'h0;
        end else begin
            wr_ph_reg <= take && hwrite;
            rd_done_reg <= rd_ph_reg && !rd_done_reg;
            if (rd_ph_reg && !rd_done_reg)
                rdata_reg <= rd_word;
            if (rd_ph_reg && rd_done_reg)
                rd_ph_reg <= 1'b0;
            if (take) begin
                addr_reg <= haddr[11:0];
                rd_ph_reg <= !hwrite;
            end
        end
    end
endmodule
`default_nettype wire

// *** vcs_pkg.sv ***
// constants, field layouts and types for the valve mode and cutoff supervisor
// assumes a 100 MHz hclk and percent values as signed whole percent
`default_nettype none
package vcs_pkg;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_PADDR = 12'h004;
    localparam logic [11:0] A_CUT = 12'h008;
    localparam logic [11:0] A_RATE = 12'h00c;
    localparam logic [11:0] A_DEV = 12'h010;
    localparam logic [11:0] A_STAT = 12'h014;
    localparam logic [11:0] A_CLK = 12'h018;
    localparam logic [11:0] A_STAMP = 12'h01c;
    localparam logic [11:0] A_ID = 12'h100;
    localparam int ID_WORDS = 28;
    localparam logic [11:0] A_ID_END = 12'h170;
    // command bits of the control word, write only
    localparam int B_WP_SET = 16;
    localparam int B_UNLOCK = 17;
    localparam int B_MODE_WR = 18;
    localparam int B_RESTART = 19;
    localparam int B_MODE = 20;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
    localparam logic [13:0] START_MIN_MS = 14'h0bb8;
    localparam logic [13:0] START_MAX_MS = 14'h2710;
    localparam logic [13:0] ABORT_MS = 14'h03e8;
    localparam logic [9:0] MS_PER_S = 10'h3e8;
    localparam logic [16:0] SEC_PER_DAY = 17'h15180;
    localparam logic signed [8:0] P_FULL = 9'sh064;
    localparam logic signed [7:0] P_CUT_HI = 8'sh7b;
    localparam logic signed [7:0] P_CUT_LO = -8'sh17;
    localparam logic signed [7:0] P_OFF_HI = 8'sh7d;
    localparam logic signed [7:0] P_OFF_LO = -8'sh19;
    localparam logic [5:0] PADDR_MAX7 = 6'h3f;
    localparam logic [5:0] PADDR_MAX5 = 6'h0f;
    typedef enum logic [1:0] {CM_ANALOG, CM_DIGITAL, CM_TEST} vcs_cmode_t;
    typedef enum logic [1:0] {SEL_TRAVEL, SEL_PRESS, SEL_FB_SENS, SEL_FB_DEV} vcs_sel_t;
    typedef enum logic [1:0] {RS_LAST, RS_ANALOG, RS_DIGITAL} vcs_rst_t;
    typedef struct packed {
        logic hart7;
        vcs_rst_t restart;
        vcs_sel_t sel;
        logic rec_auto;
        logic aux_en;
        logic cal_en;
        logic zpc_open;
        logic oos;
    } vcs_ctrl_t;
    localparam logic [9:0] CTRL_RST = 10'h210;
    typedef struct packed {
        logic lo_cut;
        logic hi_cut;
        logic signed [7:0] lo_pt;
        logic signed [7:0] hi_pt;
    } vcs_cut_t;
    localparam logic [17:0] CUT_RST = 18'h0e77d;
    localparam logic [15:0] RATE_RST = 16'h0000;
    localparam logic [23:0] DEV_RST = 24'h03e705;
endpackage
`default_nettype wire

// *** vcs_field.sv ***
// terminal box model: local calibration button and auxiliary short pins
// assumes rising-edge hclk and MS clock cycles to the millisecond
`default_nettype none
module vcs_field #(
    parameter int MS = 2
) (
    input wire logic hclk,
    output logic cal_button,
    output logic aux_short,
    output logic autocal_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cal_button = 1'b0;
        aux_short = 1'b0;
        autocal_done = 1'b0;
    end
    // one press or short, held for ms then released; the device acts on release
    task automatic hold(input logic aux, input int ms);
        @(posedge hclk);
        if (aux) begin
            aux_short <= 1'b1;
        end else begin
            cal_button <= 1'b1;
        end
        repeat (ms * MS) @(posedge hclk);
        aux_short <= 1'b0;
        cal_button <= 1'b0;
    endtask
    // calibration run reports completion for one cycle
    task automatic cal_finished();
        @(posedge hclk);
        autocal_done <= 1'b1;
        @(posedge hclk);
        autocal_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** vcs_top_chk.sv ***
// concurrent checks on the supervisor's ports, bound into vcs_top
// assumes one hclk domain and asynchronous active-low hresetn
`default_nettype none
module vcs_top_chk
    import vcs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic travel_valid,
    input wire logic signed [7:0] pressure_pct,
    input wire logic cal_button,
    input wire logic aux_short,
    input wire logic signed [7:0] travel_target,
    input wire logic signed [7:0] reported_travel,
    input wire logic pressure_ctl,
    input wire logic autocal_run,
    input wire logic stroke_test_start,
    input wire logic [1:0] control_mode,
    input wire logic write_protected
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    chk_resp_okay:
        assert property (hresp == 1'b0) else $error("bus response not okay");
    chk_read_wait:
        assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly one wait");
    chk_write_nowait:
        assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout) else $error("write stalled");
    chk_unlock_local:
        assert property ($fell(write_protected) |-> !cal_button && !$past(cal_button))
        else $error("protection cleared without a local release");
    chk_cal_locked:
        assert property ($rose(autocal_run) |-> !write_protected) else $error("autocal started while protected");
    chk_stroke_pulse:
        assert property (stroke_test_start |=> !stroke_test_start) else $error("stroke start not one cycle");
    chk_stroke_release:
        assert property (stroke_test_start |-> !aux_short && !$past(aux_short))
        else $error("stroke start before short released");
    chk_test_mode:
        assert property (autocal_run && $past(autocal_run) |-> control_mode == CM_TEST)
        else $error("autocal running outside test mode");
    chk_target_span:
        assert property (travel_target >= -8'sh19 && travel_target <= 8'sh7d) else $error("target out of span");
    chk_press_report:
        assert property ($past(pressure_ctl || !travel_valid) |-> reported_travel == $past(pressure_pct))
        else $error("reported travel not pressure");
endmodule
bind vcs_top vcs_top_chk chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .travel_valid, .pressure_pct, .cal_button, .aux_short, .travel_target, .reported_travel, .pressure_ctl,
    .autocal_run, .stroke_test_start, .control_mode, .write_protected);
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench: registers over AHB-Lite, local pins, cutoffs, fallback
// assumes vcs_field drives the terminal box pins; ms shortened to 2 cycles
`default_nettype none
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_top
    import vcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 2;
    logic hclk, hresetn = 1'b0, hwrite = 1'b0, travel_valid = 1'b1, alert_event = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic signed [7:0] setpoint_pct = 8'sh32, travel_pct = 8'sh32, pressure_pct = 8'sh2a;
    logic signed [7:0] travel_target, reported_travel;
    logic hreadyout, hresp, cal_button, aux_short, autocal_done, pressure_ctl, autocal_run, stroke_test_start;
    logic write_protected, in_service;
    logic [1:0] control_mode;
    logic [5:0] polling_addr;
    int err_total = 0, cmp_count = 0, n_stroke = 0;
    vcs_top #(.MS_CYCLES(MSC)) uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .setpoint_pct, .travel_pct, .travel_valid, .pressure_pct,
        .cal_button, .aux_short, .autocal_done, .alert_event, .travel_target, .reported_travel, .pressure_ctl,
        .autocal_run, .stroke_test_start, .control_mode, .polling_addr, .write_protected, .in_service);
    vcs_field #(.MS(MSC)) fld (.hclk, .cal_button, .aux_short, .autocal_done);
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // hready is sampled at the edge, before that edge's updates land
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk iff hreadyout);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk iff hreadyout);
        rd = hrdata;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CK(rd, e)
    endtask
    task automatic bw(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        cyc(4);
    endtask
    // sync and release handling need a few cycles after the pin drops
    task automatic press(input logic aux, input int ms);
        fld.hold(aux, ms);
        cyc(20);
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        if (stroke_test_start === 1'b1) begin
            n_stroke++;
        end
    end
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #1000000;
        err_total++;
        finish_test();
    end
    initial begin
        cyc(10);
        hresetn <= 1'b1;
        rc(A_CTRL, 32'h210);
        rc(A_CUT, 32'h0e77d);
        rc(A_DEV, 32'h03e705);
        rc(A_RATE, 32'h0);
        rc(12'h020, 32'h0);
        rc(A_STAT, 32'h20);
        bw(A_ID_END - 12'h004, 32'h7e57a9c1);
        rc(A_ID_END - 12'h004, 32'h7e57a9c1);
        `CK({in_service, write_protected, control_mode}, 4'h8)
        bw(A_CTRL, 32'h211);
        `CK(in_service, 1'b0)
        bw(A_PADDR, 32'h3f);
        bw(A_PADDR, 32'h40);
        `CK(polling_addr, 6'h00)
        bw(A_CTRL, 32'h210);
        `CK(polling_addr, 6'h3f)
        bw(A_PADDR, 32'h5);
        rc(A_PADDR, 32'h3f);
        bw(A_CTRL, 32'h011);
        bw(A_PADDR, 32'h10);
        rc(A_PADDR, 32'h3f);
        bw(A_PADDR, 32'h0f);
        bw(A_CTRL, 32'h210);
        `CK(polling_addr, 6'h0f)
        bw(A_CUT, 32'h1e75a);
        travel_pct <= 8'sh5f;
        cyc(10);
        `CK(travel_target, 8'sh7b)
        travel_pct <= 8'sh32;
        bw(A_RATE, 32'h64);
        travel_pct <= 8'sh5f;
        cyc(20);
        `CK(travel_target != 8'sh7b, 1'b1)
        cyc(4000);
        `CK(travel_target, 8'sh7b)
        bw(A_RATE, 32'h0);
        bw(A_CUT, 32'h0e73c);
        setpoint_pct <= 8'sh50;
        travel_pct <= 8'sh32;
        cyc(10);
        `CK(travel_target, 8'sh3c)
        bw(A_CUT, 32'h20a7d);
        setpoint_pct <= 8'sh32;
        travel_pct <= 8'sh05;
        cyc(10);
        `CK(travel_target, -8'sh17)
        bw(A_CUT, 32'h0e77d);
        travel_pct <= 8'sh32;
        bw(A_CTRL, 32'h212);
        setpoint_pct <= 8'sh1e;
        cyc(10);
        `CK(travel_target, 8'sh46)
        bw(A_CTRL, 32'h210);
        setpoint_pct <= 8'sh32;
        travel_valid <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            bw(A_CTRL, 32'h211 | (s << 5));
            bw(A_CTRL, 32'h210 | (s << 5));
            `CK(pressure_ctl, 1'(s != 0))
        end
        `CK(reported_travel, 8'sh2a)
        travel_valid <= 1'b1;
        cyc(10);
        `CK(pressure_ctl, 1'b0)
        bw(A_DEV, 32'h000a05);
        travel_pct <= 8'sh1e;
        cyc(10);
        travel_pct <= 8'sh32;
        cyc(4);
        travel_pct <= 8'sh1e;
        cyc(14);
        `CK(pressure_ctl, 1'b0)
        cyc(20);
        `CK(pressure_ctl, 1'b1)
        `CK(reported_travel, 8'sh2a)
        bw(A_CTRL, 32'h260);
        travel_pct <= 8'sh32;
        cyc(10);
        `CK(pressure_ctl, 1'b1)
        bw(A_CTRL, 32'h270);
        `CK(pressure_ctl, 1'b0)
        bw(A_CLK, 32'h21234);
        alert_event <= 1'b1;
        cyc(1);
        alert_event <= 1'b0;
        rc(A_STAMP, 32'h21234);
        bw(A_CTRL, 32'h274);
        bw(A_CTRL, 32'h10274);
        `CK(write_protected, 1'b1)
        bw(A_CUT, 32'h1e75a);
        rc(A_CUT, 32'h0e77d);
        press(1'b0, 3500);
        `CK(autocal_run, 1'b0)
        bw(A_CTRL, 32'h20274);
        `CK(write_protected, 1'b1)
        press(1'b0, 1500);
        `CK(write_protected, 1'b0)
        press(1'b0, 5000);
        `CK({autocal_run, control_mode}, {1'b1, CM_TEST})
        press(1'b0, 1200);
        `CK({autocal_run, control_mode}, {1'b0, CM_TEST})
        bw(A_CTRL, 32'h140274);
        `CK(control_mode, CM_DIGITAL)
        press(1'b0, 2000);
        `CK(autocal_run, 1'b0)
        press(1'b0, 4000);
        `CK(autocal_run, 1'b1)
        fld.cal_finished();
        cyc(2);
        `CK({autocal_run, control_mode}, {1'b0, CM_DIGITAL})
        bw(A_CTRL, 32'h27c);
        press(1'b1, 4000);
        `CK(n_stroke, 1)
        press(1'b1, 2500);
        `CK(n_stroke, 1)
        bw(A_CTRL, 32'h2fc);
        bw(A_CTRL, 32'h802fc);
        `CK(control_mode, CM_ANALOG)
        finish_test();
    end
endmodule
`default_nettype wire
